/* dv/dsp_properties.sv */
// Pin-level assertions for the host and radio ends of the serial link
`timescale 1ns/1ps
module dsp_properties (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cfg_sel_n,
  input  wire logic       fifo_sel_n,
  input  wire logic       miso,
  input  wire logic       miso_oe_n,
  input  wire logic       irq0_oe_n,
  input  wire logic       irq1_oe_n,
  input  wire logic       clkout_oe_n,
  input  wire logic       pll_lock_oe_n,
  input  wire logic       data_dev_oe_n,
  input  wire logic [2:0] chip_mode_o,
  input  wire logic [1:0] data_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  logic       sck_q;
  logic [4:0] n_cfg;
  logic [3:0] n_fifo;
  wire        sck_rise = sck && !sck_q;

  // Clock rises per frame; partial bytes would be dropped by the device
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_q  <= 1'b0;
      n_cfg  <= 5'h00;
      n_fifo <= 4'h0;
    end else begin
      sck_q  <= sck;
      n_cfg  <= cfg_sel_n ? 5'h00 : n_cfg + 5'(sck_rise);
      n_fifo <= fifo_sel_n ? 4'h0 : n_fifo + 4'(sck_rise);
    end
  end

  // Select path goes through a synchroniser, so allow a few cycles
  sequence both_idle_s;
    (cfg_sel_n && fifo_sel_n) [*6];
  endsequence
  sequence any_sel_s;
    (!(cfg_sel_n && fifo_sel_n)) [*6];
  endsequence

  miso_float_a: assert property (both_idle_s |-> miso_oe_n)
    else $error("miso driven with no select");
  miso_drive_a: assert property (any_sel_s |-> !miso_oe_n)
    else $error("miso not driven while selected");
  sleep_float_a: assert property ((chip_mode_o == 3'h0) [*3] |->
    irq0_oe_n && irq1_oe_n && clkout_oe_n && pll_lock_oe_n)
    else $error("pin driven in sleep");
  data_dir_a: assert property ($stable(chip_mode_o) [*3] |->
    data_dev_oe_n == (chip_mode_o != 3'h3))
    else $error("data pin direction wrong");
  irq_cont_a: assert property (((chip_mode_o inside {3'h1, 3'h2}) &&
    $stable(chip_mode_o) && $stable(data_mode_o)) [*3] |->
    (irq0_oe_n == (data_mode_o == 2'h0)) &&
    (irq1_oe_n == (data_mode_o == 2'h0)))
    else $error("irq drive wrong in standby or synth");
  cfg_pair_a: assert property ($rose(cfg_sel_n) |->
    n_cfg[3:0] == 4'h0)
    else $error("config frame not address plus value");
  fifo_byte_a: assert property ($rose(fifo_sel_n) |->
    n_fifo == 4'h8)
    else $error("fifo frame not one byte");
  sck_idle_a: assert property ((cfg_sel_n && fifo_sel_n) |-> !sck)
    else $error("serial clock runs outside frame");
  mosi_hold_a: assert property ($changed(mosi) |-> !sck)
    else $error("mosi changed while clock high");
  miso_shift_a: assert property ((!cfg_sel_n && $changed(miso))
    |-> !sck)
    else $error("miso changed while clock high");
endmodule

/* dv/tb.sv */
// Self-checking bench: host and radio ends joined by the pin bundle
`timescale 1ns/1ps
module tb;
  logic              clk_i;
  logic              reset_i;
  logic              cmd_valid;
  dsp_pkg::dsp_cmd_t cmd_kind;
  logic [4:0]        cmd_addr;
  logic [7:0]        cmd_data;
  logic              tx_ready;
  logic [7:0]        rx_byte;
  logic              rx_valid;
  logic              data_in;
  logic              data_drive;
  logic              rx_bit;
  wire               cmd_ready;
  wire               rsp_valid;
  wire  [7:0]        rsp_data;
  wire               nonempty;
  wire               full;
  wire               data_out;
  wire  [7:0]        tx_byte;
  wire               tx_valid;
  wire               rx_ready;
  wire               tx_bit;
  wire  [2:0]        chip_mode;
  wire  [1:0]        data_mode;
  int                err_count;
  int                n_compared;
  int                i;
  logic [7:0]        r;
  logic [7:0]        prev;
  logic [7:0]        ctrl_tab [8] = '{8'h0E, 8'h2E, 8'h4E, 8'h6E,
                                      8'h8E, 8'h20, 8'h62, 8'h5C};
  // Expected {irq0, irq1, clkout, lock, data} enables per control value
  logic [4:0]        pin_tab [8] = '{5'h1F, 5'h01, 5'h01, 5'h00,
                                     5'h01, 5'h1F, 5'h04, 5'h03};

  dsp_if bus ();
  dsp_host dsp_host_inst (.clk_i(clk_i), .reset_i(reset_i),
    .pins(bus.host), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .fifo_nonempty_o(nonempty), .fifo_full_o(full),
    .data_bit_o(data_out), .data_bit_i(data_in),
    .data_drive_i(data_drive));
  dsp_dev dsp_dev_inst (.clk_i(clk_i), .reset_i(reset_i),
    .pins(bus.dev), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .tx_bit_o(tx_bit), .rx_bit_i(rx_bit),
    .clk_src_i(1'b0), .pll_locked_i(1'b1), .chip_mode_o(chip_mode),
    .data_mode_o(data_mode));
  dsp_properties dsp_properties_inst (.clk_i(clk_i), .reset_i(reset_i),
    .sck(bus.sck), .mosi(bus.mosi), .cfg_sel_n(bus.cfg_sel_n),
    .fifo_sel_n(bus.fifo_sel_n), .miso(bus.miso),
    .miso_oe_n(bus.miso_oe_n), .irq0_oe_n(bus.irq0_oe_n),
    .irq1_oe_n(bus.irq1_oe_n), .clkout_oe_n(bus.clkout_oe_n),
    .pll_lock_oe_n(bus.pll_lock_oe_n), .data_dev_oe_n(bus.data_dev_oe_n),
    .chip_mode_o(chip_mode), .data_mode_o(data_mode));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One framed command; ready is read before the edge that samples it
  task automatic xfer(input dsp_pkg::dsp_cmd_t k, input logic [4:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_addr  <= a;
    cmd_data  <= d;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    for (n = 0; n < 2000 && rsp_valid !== 1'b1; n++) @(posedge clk_i);
    chk(rsp_valid, 1'b1, "response");
    r = rsp_data;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic [7:0] old);
    xfer(dsp_pkg::DSP_CFG_WR, a, d);
    chk(r, old, "old value");
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    xfer(dsp_pkg::DSP_CFG_RD, a, 8'h00);
    chk(r, exp, "read value");
  endtask

  initial begin
    #200000;
    err_count++;
    close_out();
  end

  initial begin
    reset_i = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = dsp_pkg::DSP_CFG_WR;
    cmd_addr = 5'h00;
    cmd_data = 8'h00;
    tx_ready = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    data_in = 1'b0;
    data_drive = 1'b0;
    rx_bit = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(5'h00, dsp_pkg::CTRL_RESET);
    wr(5'h05, 8'hA5, 8'h00);
    wr(5'h05, 8'h3C, 8'hA5);
    wr(5'h1F, 8'hFF, 8'h00);
    rd(5'h1F, 8'hFF);
    rd(5'h05, 8'h3C);
    rd(5'h05, 8'h3C);
    prev = dsp_pkg::CTRL_RESET;
    for (i = 0; i < 8; i++) begin
      fork
        wr(5'h00, ctrl_tab[i], prev);
        begin
          @(posedge bus.cfg_sel_n);
          chk(chip_mode, prev[7:5], "mode at rise");
        end
      join
      repeat (5) @(posedge clk_i);
      chk(chip_mode, ctrl_tab[i][7:5], "chip mode");
      chk(data_mode, ctrl_tab[i][4:3], "data mode");
      chk({bus.irq0_oe_n, bus.irq1_oe_n, bus.clkout_oe_n,
           bus.pll_lock_oe_n, bus.data_dev_oe_n}, pin_tab[i], "pins");
      prev = ctrl_tab[i];
    end
    // FIFO port is dead in continuous mode, live in packet mode
    wr(5'h00, 8'h20, prev);
    xfer(dsp_pkg::DSP_FIFO_WR, 5'h00, 8'h11);
    wr(5'h00, 8'h30, 8'h20);
    repeat (5) @(posedge clk_i);
    chk(nonempty, 1'b0, "ignored byte");
    for (i = 0; i < 9; i++) xfer(dsp_pkg::DSP_FIFO_WR, 5'h00, 8'hB0 + 8'(i));
    repeat (5) @(posedge clk_i);
    chk(nonempty, 1'b1, "nonempty");
    chk(full, 1'b1, "full");
    wr(5'h00, 8'h90, 8'h30);
    for (i = 0; i < 8; i++) begin
      repeat (4) @(posedge clk_i);
      chk(tx_valid, 1'b1, "tx valid");
      chk(tx_byte, 8'hB0 + 8'(i), "tx byte");
      tx_ready <= 1'b1;
      @(posedge clk_i);
      tx_ready <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    chk(tx_valid, 1'b0, "overflow dropped");
    // Receive side fills the FIFO; host reads one byte per frame
    wr(5'h00, 8'h70, 8'h90);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i);
      rx_byte  <= i ? 8'h42 : 8'h81;
      rx_valid <= 1'b1;
      while (rx_ready !== 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      rx_valid <= 1'b0;
    end
    xfer(dsp_pkg::DSP_FIFO_RD, 5'h00, 8'h00);
    chk(r, 8'h81, "fifo read");
    repeat (30) @(posedge clk_i);
    chk(nonempty, 1'b1, "more left");
    xfer(dsp_pkg::DSP_FIFO_RD, 5'h00, 8'h00);
    chk(r, 8'h42, "fifo read");
    repeat (30) @(posedge clk_i);
    chk(nonempty, 1'b0, "drained");
    xfer(dsp_pkg::DSP_FIFO_RD, 5'h00, 8'h00);
    chk(r, 8'h00, "empty read");
    // Continuous mode: bits pass straight through the data pin
    wr(5'h00, 8'h60, 8'h70);
    for (i = 1; i >= 0; i--) begin
      rx_bit <= i[0];
      repeat (6) @(posedge clk_i);
      chk(data_out, i[0], "rx bit");
    end
    wr(5'h00, 8'h80, 8'h60);
    data_drive <= 1'b1;
    for (i = 1; i >= 0; i--) begin
      data_in <= i[0];
      repeat (6) @(posedge clk_i);
      chk(tx_bit, i[0], "tx bit");
    end
    data_drive <= 1'b0;
    close_out();
  end
endmodule

/* logic/dsp_dev.sv */
// Radio digital section: config and FIFO serial slaves, pin control
`timescale 1ns/1ps
module dsp_dev #(
  parameter int NREG  = dsp_pkg::NUM_REGS,
  parameter int DEPTH = dsp_pkg::FIFO_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  dsp_if.dev              pins,
  output logic      [7:0] tx_byte_o,
  output wire logic       tx_valid_o,
  input  wire logic       tx_ready_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       rx_valid_i,
  output wire logic       rx_ready_o,
  output logic            tx_bit_o,
  input  wire logic       rx_bit_i,
  input  wire logic       clk_src_i,
  input  wire logic       pll_locked_i,
  output wire logic [2:0] chip_mode_o,
  output wire logic [1:0] data_mode_o
);
  localparam int BW = dsp_pkg::BYTE_W;
  localparam int AW = dsp_pkg::ADDR_W;

  logic [dsp_pkg::SYN_W-1:0] meta;
  logic [dsp_pkg::SYN_W-1:0] sync;
  logic [dsp_pkg::SYN_W-1:0] sync_d;
  wire  [dsp_pkg::SYN_W-1:0] raw = {pins.data_line, pins.fifo_sel_n,
                                    pins.cfg_sel_n, pins.mosi, pins.sck};

  // Every pin passes two flops; edges come from the second and a third
  for (genvar i = 0; i < dsp_pkg::SYN_W; i++) begin : g_sync
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        meta[i]   <= dsp_pkg::SYN_RESET[i];
        sync[i]   <= dsp_pkg::SYN_RESET[i];
        sync_d[i] <= dsp_pkg::SYN_RESET[i];
      end else begin
        meta[i]   <= raw[i];
        sync[i]   <= meta[i];
        sync_d[i] <= sync[i];
      end
    end
  end

  wire mosi_s   = sync[dsp_pkg::SYN_MOSI];
  wire data_s   = sync[dsp_pkg::SYN_DATA];
  wire sck_rise = sync[dsp_pkg::SYN_SCK] & ~sync_d[dsp_pkg::SYN_SCK];
  wire sck_fall = ~sync[dsp_pkg::SYN_SCK] & sync_d[dsp_pkg::SYN_SCK];
  wire cfg_sel  = ~sync[dsp_pkg::SYN_CFG];
  wire cfg_fall = cfg_sel & sync_d[dsp_pkg::SYN_CFG];
  wire cfg_rise = ~cfg_sel & ~sync_d[dsp_pkg::SYN_CFG];
  wire fifo_sel = ~sync[dsp_pkg::SYN_FIFO] & ~cfg_sel;
  wire fifo_fall = fifo_sel & sync_d[dsp_pkg::SYN_FIFO];
  wire fifo_rise = sync[dsp_pkg::SYN_FIFO] & ~sync_d[dsp_pkg::SYN_FIFO]
                 & ~cfg_sel;
  wire any_sel  = cfg_sel | fifo_sel;

  // Live and staged register copies
  logic [BW-1:0] active [NREG];
  logic [BW-1:0] shadow [NREG];
  wire  [BW-1:0] ctrl = active[dsp_pkg::CTRL_ADDR];

  assign chip_mode_o = ctrl[dsp_pkg::CHIP_MSB -: 3];
  assign data_mode_o = ctrl[dsp_pkg::DMODE_MSB -: 2];

  // Mode decode
  wire is_sleep = chip_mode_o == dsp_pkg::DSP_SLEEP;
  wire is_stby  = chip_mode_o == dsp_pkg::DSP_STANDBY;
  wire is_synth = chip_mode_o == dsp_pkg::DSP_SYNTH;
  wire is_rx    = chip_mode_o == dsp_pkg::DSP_RX;
  wire is_tx    = chip_mode_o == dsp_pkg::DSP_TX;
  wire is_cont  = data_mode_o == dsp_pkg::DMODE_CONT;
  wire is_pkt   = data_mode_o[1];
  wire fifo_on  = ~is_cont;

  // Serial shifter shared by both slaves
  logic [BW-1:0] rx_sr;
  logic [BW-1:0] tx_sr;
  logic [2:0]    bit_cnt;
  logic          data_phase;
  logic          rd_q;
  logic [AW-1:0] addr_q;
  logic [BW-1:0] push_byte;
  logic          push_pend;
  logic [dsp_pkg::PKT_CNT_W-1:0] pkt_cnt;

  wire [BW-1:0] byte_now  = {rx_sr[BW-2:0], mosi_s};
  wire          byte_done = sck_rise & any_sel & (bit_cnt == 3'h7);
  wire          cfg_done  = byte_done & cfg_sel;
  wire          cfg_wr    = cfg_done & data_phase & ~rd_q;
  wire          cfg_load  = sck_fall & cfg_sel & (bit_cnt == 3'h0);
  wire [AW-1:0] addr_now  = byte_now[AW-1:0];

  // FIFO hookup: rx mode fills from the radio, otherwise from the host
  wire          f_in_ready;
  wire          f_out_valid;
  wire [BW-1:0] f_out_data;
  wire pkt_room = ~is_pkt
                | (pkt_cnt < dsp_pkg::PKT_CNT_W'(dsp_pkg::PKT_MAX_BYTES));
  wire spi_push = fifo_rise & push_pend & fifo_on & ~is_rx
                & pkt_room;
  wire rad_push = is_rx & fifo_on & rx_valid_i;
  wire spi_pop  = fifo_fall & is_rx & fifo_on & f_out_valid;
  wire f_in_valid = is_rx ? rad_push : spi_push;
  wire [BW-1:0] f_in_data = is_rx ? rx_byte_i : push_byte;
  wire f_out_ready = is_rx ? spi_pop : (is_tx & tx_ready_i);

  assign rx_ready_o = is_rx & fifo_on & f_in_ready;
  assign tx_valid_o = is_tx & fifo_on & f_out_valid;

  dsp_fifo #(
    .W (BW),
    .D (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_sr      <= '0;
      bit_cnt    <= '0;
      data_phase <= 1'b0;
      rd_q       <= 1'b0;
      addr_q     <= '0;
      push_byte  <= '0;
      push_pend  <= 1'b0;
    end else if (cfg_fall | fifo_fall) begin
      bit_cnt    <= '0;
      data_phase <= 1'b0;
      push_pend  <= 1'b0;
    end else if (sck_rise & any_sel) begin
      rx_sr   <= byte_now;
      bit_cnt <= bit_cnt + 3'h1;
      if (cfg_done) begin
        data_phase <= ~data_phase;
        if (!data_phase) begin
          addr_q <= addr_now;
          rd_q   <= byte_now[dsp_pkg::RD_FLAG_BIT];
        end
      end else if (byte_done) begin
        push_byte <= byte_now;
        push_pend <= 1'b1;
      end
    end
  end

  // MISO source: old register value, popped byte, or zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_sr <= '0;
    end else if (fifo_fall) begin
      tx_sr <= spi_pop ? f_out_data : '0;
    end else if (cfg_fall) begin
      tx_sr <= '0;
    end else if (cfg_load) begin
      // Loaded on the clock fall so MISO never moves while SCK is high
      tx_sr <= data_phase ? active[addr_q] : '0;
    end else if (sck_fall & any_sel & (bit_cnt != 3'h0)) begin
      tx_sr <= {tx_sr[BW-2:0], 1'b0};
    end
  end

  // Staged writes only go live when the config select rises
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NREG; i++) begin
        shadow[i] <= (i == 0) ? dsp_pkg::CTRL_RESET : dsp_pkg::REG_RESET;
        active[i] <= (i == 0) ? dsp_pkg::CTRL_RESET : dsp_pkg::REG_RESET;
      end
    end else begin
      if (cfg_wr) begin
        shadow[addr_q] <= byte_now;
      end
      if (cfg_rise) begin
        active <= shadow;
      end
    end
  end

  // Packet payload counter restarts on any config update or empty FIFO
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pkt_cnt <= '0;
    end else if (cfg_rise | (~f_out_valid & ~spi_push)) begin
      pkt_cnt <= '0;
    end else if (spi_push) begin
      pkt_cnt <= pkt_cnt + 1'b1;
    end
  end

  // Status flags: not-empty refreshes at select fall, not mid-frame
  logic fifo_fall_d;
  logic nonempty_q;
  logic full_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fifo_fall_d <= 1'b0;
      nonempty_q  <= 1'b0;
      full_q      <= 1'b0;
      tx_bit_o    <= 1'b0;
      pins.data_dev <= 1'b0;
      pins.clkout   <= 1'b0;
      pins.pll_lock <= 1'b0;
    end else begin
      fifo_fall_d <= fifo_fall;
      if (~fifo_sel | fifo_fall_d) begin
        nonempty_q <= f_out_valid;
      end
      full_q   <= ~f_in_ready;
      tx_bit_o <= (is_tx & is_cont) ? data_s : 1'b0;
      pins.data_dev <= rx_bit_i;
      pins.clkout   <= clk_src_i;
      pins.pll_lock <= pll_locked_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_byte_o <= '0;
    end else begin
      tx_byte_o <= f_out_data;
    end
  end

  // Pin enables, low while driving
  wire irq_float = is_sleep | ((is_stby | is_synth) & is_cont);
  assign pins.miso          = tx_sr[BW-1];
  assign pins.miso_oe_n     = ~any_sel;
  assign pins.irq0          = nonempty_q;
  assign pins.irq1          = full_q;
  assign pins.irq0_oe_n     = irq_float;
  assign pins.irq1_oe_n     = irq_float;
  assign pins.clkout_oe_n   = is_sleep
                            | ~ctrl[dsp_pkg::CLKOUT_EN_BIT];
  assign pins.pll_lock_oe_n = is_sleep
                            | ~ctrl[dsp_pkg::LOCK_EN_BIT];
  assign pins.data_dev_oe_n = ~is_rx;
endmodule

/* logic/dsp_fifo.sv */
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dsp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         in_valid_i,
  output wire logic         in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output wire logic         out_valid_o,
  input  wire logic         out_ready_i,
  output wire logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire do_push = in_valid_i & in_ready_o;
  wire do_pop  = out_valid_o & out_ready_i;
  assign in_ready_o  = count != DEPTH;
  assign out_valid_o = count != '0;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Storage carries no reset; empty flag guards reads
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

/* logic/dsp_host.sv */
// Host end: serial master for the config and FIFO ports
`timescale 1ns/1ps
module dsp_host #(
  parameter int HALF = dsp_pkg::SCK_HALF_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  dsp_if.host                            pins,
  input  wire logic                      cmd_valid_i,
  output wire logic                      cmd_ready_o,
  input  wire dsp_pkg::dsp_cmd_t         cmd_kind_i,
  input  wire logic [dsp_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [7:0]                cmd_data_i,
  output logic                           rsp_valid_o,
  output logic      [7:0]                rsp_data_o,
  output logic                           fifo_nonempty_o,
  output logic                           fifo_full_o,
  output logic                           data_bit_o,
  input  wire logic                      data_bit_i,
  input  wire logic                      data_drive_i
);
  localparam int NB = dsp_pkg::CFG_BITS;
  localparam int SW = 4;

  dsp_pkg::dsp_hstate_t state;
  logic [dsp_pkg::TMR_W-1:0] tmr;
  logic [NB-1:0] tx_sr;
  logic [NB-1:0] rx_sr;
  logic [4:0]    cnt;
  logic [4:0]    last;
  logic [SW-1:0] meta;
  logic [SW-1:0] sync;

  wire [SW-1:0] raw = {pins.data_line, pins.irq1, pins.irq0,
                       pins.miso_line};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  wire tick = tmr == '0;
  wire is_cfg = ~cmd_kind_i[1];
  wire rd_cmd = cmd_kind_i == dsp_pkg::DSP_CFG_RD;
  wire [7:0] addr_byte = {rd_cmd, {(7-dsp_pkg::ADDR_W){1'b0}}, cmd_addr_i};
  wire [NB-1:0] frame = is_cfg ? {addr_byte, cmd_data_i}
                                : {cmd_data_i, 8'h00};
  assign cmd_ready_o = state == dsp_pkg::H_IDLE;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state       <= dsp_pkg::H_IDLE;
      tmr         <= '0;
      tx_sr       <= '0;
      rx_sr       <= '0;
      cnt         <= '0;
      last        <= '0;
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
      pins.sck        <= 1'b0;
      pins.mosi       <= 1'b0;
      pins.cfg_sel_n  <= 1'b1;
      pins.fifo_sel_n <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      tmr <= tick ? dsp_pkg::TMR_W'(HALF - 1) : tmr - 1'b1;
      unique case (state)
        dsp_pkg::H_IDLE: begin
          if (cmd_valid_i) begin
            tx_sr <= frame;
            cnt   <= '0;
            last  <= is_cfg ? 5'h0F : 5'h07;
            pins.cfg_sel_n  <= ~is_cfg;
            pins.fifo_sel_n <= is_cfg;
            pins.mosi <= frame[NB-1];
            tmr   <= dsp_pkg::TMR_W'(HALF - 1);
            state <= dsp_pkg::H_SETUP;
          end
        end
        dsp_pkg::H_SETUP: begin
          if (tick) begin
            state <= dsp_pkg::H_SHIFT;
          end
        end
        dsp_pkg::H_SHIFT: begin
          if (tick && !pins.sck) begin
            pins.sck <= 1'b1;
            rx_sr <= {rx_sr[NB-2:0], sync[0]};
          end else if (tick) begin
            pins.sck <= 1'b0;
            cnt <= cnt + 5'h1;
            if (cnt == last) begin
              state <= dsp_pkg::H_GAP;
            end else begin
              tx_sr <= {tx_sr[NB-2:0], 1'b0};
              pins.mosi <= tx_sr[NB-2];
            end
          end
        end
        dsp_pkg::H_GAP: begin
          // Select rises after every frame, one byte per FIFO frame
          pins.cfg_sel_n  <= 1'b1;
          pins.fifo_sel_n <= 1'b1;
          if (tick) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= rx_sr[7:0];
            state <= dsp_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fifo_nonempty_o <= 1'b0;
      fifo_full_o     <= 1'b0;
      data_bit_o      <= 1'b0;
      pins.data_host  <= 1'b0;
    end else begin
      fifo_nonempty_o <= sync[1];
      fifo_full_o     <= sync[2];
      data_bit_o      <= sync[3];
      pins.data_host  <= data_bit_i;
    end
  end
  assign pins.data_host_oe_n = ~data_drive_i;
endmodule

/* logic/dsp_if.sv */
// Pin bundle between the host and the radio digital section
`timescale 1ns/1ps
interface dsp_if;
  logic sck;
  logic mosi;
  logic cfg_sel_n;
  logic fifo_sel_n;
  logic miso;
  logic miso_oe_n;
  logic irq0;
  logic irq0_oe_n;
  logic irq1;
  logic irq1_oe_n;
  logic clkout;
  logic clkout_oe_n;
  logic pll_lock;
  logic pll_lock_oe_n;
  logic data_dev;
  logic data_dev_oe_n;
  logic data_host;
  logic data_host_oe_n;
  logic data_line;
  logic miso_line;

  // Undriven lines read as a weak high
  assign data_line = !data_dev_oe_n ? data_dev
                   : (!data_host_oe_n ? data_host : 1'b1);
  assign miso_line = !miso_oe_n ? miso : 1'b1;

  modport dev (
    input  sck, mosi, cfg_sel_n, fifo_sel_n, data_line,
    output miso, miso_oe_n, irq0, irq0_oe_n, irq1, irq1_oe_n,
    output clkout, clkout_oe_n, pll_lock, pll_lock_oe_n,
    output data_dev, data_dev_oe_n
  );
  modport host (
    output sck, mosi, cfg_sel_n, fifo_sel_n, data_host, data_host_oe_n,
    input  miso_line, irq0, irq1, data_line
  );
endinterface

/* logic/dsp_pkg.sv */
// Constants and types shared by both ends of the dual serial port link
// Contract
// - Chip mode codes: sleep, standby, synth, rx, tx
// - Sleep floats irq, clock, lock; data pin rx-only
// - Standby/synth irq float in continuous mode
// - Lock pin driven only when enable bit set
// - MISO driven only while a select is low
// - Data mode 00 continuous, 01 buffered, 1x packet
// - Continuous bits bypass FIFO via data pin
// - Buffered bytes pass FIFO over data port
// - Packet payload limited to 64 bytes
// - Config always served; FIFO port only buffered/packet
// - Two slaves share clock and data lines
// - Config select wins over FIFO select
// - Written values apply at config select rise
// - Old register value shifts out during write
// - Held select: alternating address, value bytes written
// - Held select: alternating address, value bytes read
// - FIFO byte pushed at select rise
// - Host frames each FIFO read byte separately
// - Empty flag updated at select fall; host checks (dsp_host reads without checking it; an empty read returns zero)
package dsp_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          CFG_BITS      = 16;
  localparam int          NUM_REGS      = 32;
  localparam int          ADDR_W        = 5;
  localparam int          RD_FLAG_BIT   = 7;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          PKT_MAX_BYTES = 64;
  localparam int          PKT_CNT_W     = 7;
  // Control register: chip mode, data mode, clock and lock enables
  localparam logic [4:0]  CTRL_ADDR     = 5'h00;
  localparam int          CHIP_MSB      = 7;
  localparam int          DMODE_MSB     = 4;
  localparam int          CLKOUT_EN_BIT = 2;
  localparam int          LOCK_EN_BIT   = 1;
  localparam logic [7:0]  CTRL_RESET    = 8'h20;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  // Synchroniser lanes and their reset levels
  localparam int          SYN_W         = 5;
  localparam int          SYN_SCK       = 0;
  localparam int          SYN_MOSI      = 1;
  localparam int          SYN_CFG       = 2;
  localparam int          SYN_FIFO      = 3;
  localparam int          SYN_DATA      = 4;
  localparam logic [4:0]  SYN_RESET     = 5'h0C;
  // Host serial clock timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SCK_HALF_NS   = 80;
  localparam int          SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;
  localparam int          TMR_W         = 8;

  typedef enum logic [2:0] {
    DSP_SLEEP   = 3'h0,
    DSP_STANDBY = 3'h1,
    DSP_SYNTH   = 3'h2,
    DSP_RX      = 3'h3,
    DSP_TX      = 3'h4
  } dsp_chip_t;

  localparam logic [1:0]  DMODE_CONT    = 2'h0;
  localparam logic [1:0]  DMODE_BUF     = 2'h1;

  typedef enum logic [1:0] {
    DSP_CFG_WR  = 2'h0,
    DSP_CFG_RD  = 2'h1,
    DSP_FIFO_WR = 2'h2,
    DSP_FIFO_RD = 2'h3
  } dsp_cmd_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_SETUP = 4'h2,
    H_SHIFT = 4'h4,
    H_GAP   = 4'h8
  } dsp_hstate_t;
endpackage
